// [logic/tpa_map.svh]
// register offsets, field positions, reset values and timing counts for the thermal pin block
`ifndef TPA_MAP_SVH
`define TPA_MAP_SVH
`define TPA_REG_R1_CFG 8'h5F
`define TPA_REG_LOC_CFG 8'h60
`define TPA_REG_R2_CFG 8'h61
`define TPA_REG_R1_CRIT 8'h6A
`define TPA_REG_LOC_CRIT 8'h6B
`define TPA_REG_R2_CRIT 8'h6C
`define TPA_REG_STATUS2 8'h42
`define TPA_REG_MASK2 8'h75
`define TPA_REG_TIMER 8'h79
`define TPA_REG_LIMIT 8'h7A
`define TPA_REG_CTRL 8'h7C
`define TPA_BIT_THERMAL_EVENT_PIN_EN 3
`define TPA_BIT_FLAG 5
`define TPA_BIT_PIN_EN 1
`define TPA_RST_CFG 8'h00
`define TPA_RST_CRIT 8'h64
`define TPA_RST_MASK 8'h00
`define TPA_RST_LIMIT 8'h00
`define TPA_RST_CTRL 8'h02
`define TPA_CLK_HZ 25000000
`define TPA_STEP_US 22760
`define TPA_STEP_CYC ((`TPA_CLK_HZ / 1000000) * `TPA_STEP_US)
`endif

// [logic/tpa_pkg.sv]
// types shared by the thermal pin block
package tpa_pkg;
	typedef struct packed {
		logic [2:0][7:0] cfg;
		logic [2:0][7:0] crit;
		logic [2:0] over;
		logic [7:0] mask2;
		logic [7:0] limit;
		logic [7:0] ctrl;
		logic flag;
		logic [7:0] timer;
		logic timer_lsb_mode;
		logic [23:0] step_cnt;
		logic first_seen;
		logic pin_s1;
		logic pin_s2;
		logic pin_prev;
		logic waitreq;
		logic [31:0] rdata;
		logic rd_hit;
	} tpa_state_type;
endpackage : tpa_pkg

// [logic/tpa_thermal_pin.sv]
// thermal event pin input timer, alert flag and critical-limit output driver
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
`include "tpa_map.svh"
// ----------------------------------------
// ----------------------------------------
module tpa_thermal_pin (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [2:0][9:0] temp_result,
	input wire logic [2:0] temp_valid,
	input wire logic thermal_event_pin_in,
	output logic thermal_event_pin_out,
	output logic thermal_event_pin_oe,
	output logic irq
);
	tpa_pkg::tpa_state_type s_r;
	tpa_pkg::tpa_state_type s_nxt;
	logic asserted;
	logic bus_req;
	logic wr_lo;
	logic [7:0] wbyte;
	logic [7:0] rd_byte;
	logic [8:0] timer_inc;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// pin is active low; second sync stage only is read
	assign asserted = s_r.ctrl[`TPA_BIT_PIN_EN] & ~s_r.pin_s2;
	assign bus_req = (avs_read | avs_write) & s_r.waitreq;
	// a write lands at the edge where the master sees waitrequest low, not at the accept edge
	assign wr_lo = avs_write & ~s_r.waitreq & avs_byteenable[0];
	assign wbyte = avs_writedata[7:0];
	assign timer_inc = {1'b0, s_r.timer} + 9'h001;
	// read mux over the byte registers
	always_comb begin
		case (avs_address)
			`TPA_REG_R1_CFG: rd_byte = s_r.cfg[0];
			`TPA_REG_LOC_CFG: rd_byte = s_r.cfg[1];
			`TPA_REG_R2_CFG: rd_byte = s_r.cfg[2];
			`TPA_REG_R1_CRIT: rd_byte = s_r.crit[0];
			`TPA_REG_LOC_CRIT: rd_byte = s_r.crit[1];
			`TPA_REG_R2_CRIT: rd_byte = s_r.crit[2];
			`TPA_REG_MASK2: rd_byte = s_r.mask2;
			`TPA_REG_LIMIT: rd_byte = s_r.limit;
			`TPA_REG_CTRL: rd_byte = s_r.ctrl;
			`TPA_REG_TIMER: rd_byte = s_r.timer;
			`TPA_REG_STATUS2: rd_byte = {2'h0, s_r.flag, 5'h00};
			default: rd_byte = 8'h00;
		endcase
	end
	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.pin_s1 = thermal_event_pin_in;
		s_nxt.pin_s2 = s_r.pin_s1;
		s_nxt.pin_prev = asserted;
		// bus: one wait cycle then answer
		s_nxt.waitreq = 1'b1;
		s_nxt.rd_hit = 1'b0;
		if (bus_req) begin
			s_nxt.waitreq = 1'b0;
			if (avs_read) begin
				s_nxt.rdata = {24'h000000, rd_byte};
				s_nxt.rd_hit = (avs_address == `TPA_REG_TIMER);
			end
		end
		if (wr_lo) begin
			case (avs_address)
				`TPA_REG_R1_CFG: s_nxt.cfg[0] = wbyte;
				`TPA_REG_LOC_CFG: s_nxt.cfg[1] = wbyte;
				`TPA_REG_R2_CFG: s_nxt.cfg[2] = wbyte;
				`TPA_REG_R1_CRIT: s_nxt.crit[0] = wbyte;
				`TPA_REG_LOC_CRIT: s_nxt.crit[1] = wbyte;
				`TPA_REG_R2_CRIT: s_nxt.crit[2] = wbyte;
				`TPA_REG_MASK2: s_nxt.mask2 = wbyte;
				`TPA_REG_LIMIT: s_nxt.limit = wbyte;
				`TPA_REG_CTRL: s_nxt.ctrl = wbyte;
				default: s_nxt.ctrl = s_nxt.ctrl;
			endcase
		end
		// timer clear on read, taken at the accept edge
		if (bus_req & avs_read & (avs_address == `TPA_REG_TIMER)) begin
			s_nxt.timer = 8'h00;
			s_nxt.timer_lsb_mode = 1'b0;
			s_nxt.step_cnt = 24'h000000;
			s_nxt.first_seen = 1'b0;
		end else if (asserted) begin
			// first assertion sets bit 0
			if (!s_r.first_seen) begin
				s_nxt.first_seen = 1'b1;
				s_nxt.timer = s_r.timer | 8'h01;
			end
			if (s_r.step_cnt == 24'(`TPA_STEP_CYC - 1)) begin
				s_nxt.step_cnt = 24'h000000;
				if (!s_r.timer_lsb_mode) begin
					// count steps silently until one has passed
					if (s_r.timer[7:1] == 7'h00 && !s_r.timer[0]) begin
						s_nxt.timer = 8'h01;
					end else if (s_r.timer == 8'h01 && s_r.step_cnt != 24'h000000) begin
						s_nxt.timer = 8'h01;
					end
					s_nxt.timer_lsb_mode = s_r.timer_lsb_mode | s_r.first_seen & s_r.timer[0] & s_r.pin_prev;
					if (s_r.timer_lsb_mode) begin
						s_nxt.timer = s_r.timer;
					end
				end
				if (s_r.timer_lsb_mode) begin
					if (!timer_inc[8]) begin
						s_nxt.timer = timer_inc[7:0];
					end
				end
			end else begin
				s_nxt.step_cnt = s_r.step_cnt + 24'h000001;
			end
		end
		// after the first full step the timer reads two steps
		if (asserted && !s_r.timer_lsb_mode && s_nxt.timer_lsb_mode) begin
			s_nxt.timer = 8'h02;
		end
		// flag: hardware set wins over software clear
		if (wr_lo && avs_address == `TPA_REG_STATUS2 && wbyte[`TPA_BIT_FLAG]) begin
			s_nxt.flag = 1'b0;
		end
		if ((s_r.limit == 8'h00 && asserted) || (s_r.limit != 8'h00 && s_r.timer > s_r.limit)) begin
			s_nxt.flag = 1'b1;
		end
		// per-channel compare refreshed on each measurement
		for (int i = 0; i < 3; i++) begin
			if (temp_valid[i]) begin
				// result in quarter degrees, limit in whole degrees of the same encoding
				s_nxt.over[i] = (temp_result[i] > {s_r.crit[i], 2'b00});
			end
		end
		s_nxt.pin_s1 = thermal_event_pin_in;
	end
	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_r <= '0;
			s_r.cfg <= {3{`TPA_RST_CFG}};
			s_r.crit <= {3{`TPA_RST_CRIT}};
			s_r.mask2 <= `TPA_RST_MASK;
			s_r.limit <= `TPA_RST_LIMIT;
			s_r.ctrl <= `TPA_RST_CTRL;
			s_r.pin_s1 <= 1'b1;
			s_r.pin_s2 <= 1'b1;
			s_r.waitreq <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign avs_waitrequest = s_r.waitreq;
	assign avs_readdata = s_r.rdata;
	assign thermal_event_pin_out = 1'b0;
	// drive low while any enabled channel is over
	assign thermal_event_pin_oe = |(s_r.over & {s_r.cfg[2][`TPA_BIT_THERMAL_EVENT_PIN_EN], s_r.cfg[1][`TPA_BIT_THERMAL_EVENT_PIN_EN],
		s_r.cfg[0][`TPA_BIT_THERMAL_EVENT_PIN_EN]});
	assign irq = s_r.flag & ~s_r.mask2[`TPA_BIT_FLAG];
endmodule : tpa_thermal_pin

// [sim/tb_tpa_thermal_pin.sv]
// self-checking bench for the thermal pin block
`timescale 1ns/10ps
module tb_tpa_thermal_pin;
	logic ref_clk = 1'h0, reset = 1'h1, rd = 1'h0, wr = 1'h0, hot = 1'h0, oe, irq, wq, pl;
	logic [7:0] ad = 8'h00, wd = 8'h00, c;
	logic [31:0] q, x = 32'h00007548;
	logic [7:0] eq[$];
	logic [2:0][9:0] tr = 30'h00000000;
	logic [2:0] tv = 3'h0;
	int miscompares = 0, n_compared = 0;
	tpa_thermal_pin dut_u (.ref_clk(ref_clk), .reset(reset), .avs_address(ad), .avs_read(rd), .avs_write(wr),
		.avs_writedata({24'h000000, wd}), .avs_byteenable(4'hF), .avs_readdata(q), .avs_waitrequest(wq),
		.temp_result(tr), .temp_valid(tv), .thermal_event_pin_in(pl), .thermal_event_pin_out(),
		.thermal_event_pin_oe(oe), .irq(irq));
	tpa_hot_model hot_u (.hot(hot), .oe(oe), .level(pl));
	initial forever #20 ref_clk = ~ref_clk;
	task end_sim;
		if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task chk(logic [31:0] g, logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	endtask : chk
	function logic [31:0] rnd();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : rnd
	task tick(int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	// one bus transfer, held until waitrequest is seen low
	task bus(logic w, logic [7:0] a, logic [7:0] d);
		int n;
		ad <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wq !== 1'h0 && n < 20);
		if (n >= 20) begin
			miscompares++;
			end_sim();
		end
		rd <= 1'h0;
		wr <= 1'h0;
		tick(1);
	endtask : bus
	task rdx(logic [7:0] a, logic [7:0] e);
		eq.push_back(e);
		bus(1'h0, a, 8'h00);
	endtask : rdx
	// one measurement pulse, then the pin drive it leaves behind
	task meas(int i, logic [9:0] v, logic e);
		tr[i] <= v;
		tv[i] <= 1'h1;
		tick(1);
		tv <= 3'h0;
		tick(1);
		chk(oe, e);
	endtask : meas
	task pulse;
		hot <= 1'h1;
		tick(6);
		hot <= 1'h0;
		tick(4);
	endtask : pulse
	// read results against the oldest note
	always @(posedge ref_clk) if (rd && wq === 1'h0) chk(q, {24'h000000, eq.pop_front()});
	initial begin
		tick(4);
		reset <= 1'h0;
		rdx(8'h5F, 8'h00);
		rdx(8'h6C, 8'h64);
		rdx(8'h10, 8'h00);
		bus(1'h1, 8'h75, 8'h20);
		pulse();
		chk(irq, 1'h0);
		rdx(8'h42, 8'h20);
		rdx(8'h79, 8'h01);
		rdx(8'h79, 8'h00);
		bus(1'h1, 8'h75, 8'h00);
		tick(1);
		chk(irq, 1'h1);
		bus(1'h1, 8'h42, 8'h20);
		tick(1);
		chk(irq, 1'h0);
		bus(1'h1, 8'h7A, 8'h01);
		pulse();
		rdx(8'h42, 8'h00);
		for (int i = 0; i < 3; i++) begin
			c = 8'(rnd() & 32'h0000007F);
			bus(1'h1, 8'(8'h6A + i), c);
			meas(i, {c, 2'h1}, 1'h0);
			bus(1'h1, 8'(8'h5F + i), 8'h08);
			meas(i, {c, 2'h1}, 1'h1);
			tr[i] <= {c, 2'h0};
			tick(3);
			chk(oe, 1'h1);
			meas(i, {c, 2'h2}, 1'h1);
			meas(i, {c, 2'h0}, 1'h0);
		end
		meas(0, 10'h3FF, 1'h1);
		meas(2, 10'h3FF, 1'h1);
		meas(0, 10'h000, 1'h1);
		meas(2, 10'h000, 1'h0);
		end_sim();
	end
endmodule : tb_tpa_thermal_pin

// [sim/tpa_hot_model.sv]
// processor hot source sharing the pulled-up thermal pin
`timescale 1ns/10ps
module tpa_hot_model (
	input wire logic hot,
	input wire logic oe,
	output logic level
);
	// wired low by either party, pull-up otherwise
	assign level = !(hot || oe);
endmodule : tpa_hot_model

// [sim/tpa_thermal_pin_sva.sv]
// port-level assertions for the thermal pin block
`timescale 1ns/10ps
module tpa_thermal_pin_sva (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [2:0] temp_valid,
	input wire logic thermal_event_pin_out,
	input wire logic thermal_event_pin_oe,
	input wire logic irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// request steps: taken while waiting, answered for exactly one cycle
	sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
	property p_ack; s_req |=> s_ack; endproperty
	property p_idle; !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest; endproperty
	property p_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
	property p_hi0; !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000; endproperty
	property p_hold; $changed(avs_readdata) |-> avs_read && !avs_waitrequest; endproperty
	property p_drv0; thermal_event_pin_out == 1'h0; endproperty
	property p_oe; $changed(thermal_event_pin_oe) |-> $past(|temp_valid || (avs_write && !avs_waitrequest)); endproperty
	property p_irq; $fell(irq) |-> $past(avs_write && !avs_waitrequest); endproperty
	a_ack: assert property (p_ack) else $error("bad answer");
	a_idle: assert property (p_idle) else $error("answer without request");
	a_cause: assert property (p_cause) else $error("stray answer");
	a_hi0: assert property (p_hi0) else $error("upper read bits set");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_drv0: assert property (p_drv0) else $error("pin not driven low");
	a_oe: assert property (p_oe) else $error("pin moved off measurement");
	a_irq: assert property (p_irq) else $error("interrupt dropped alone");
endmodule : tpa_thermal_pin_sva
bind tpa_thermal_pin tpa_thermal_pin_sva chk_u (.ref_clk(ref_clk), .reset(reset), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .temp_valid(temp_valid),
	.thermal_event_pin_out(thermal_event_pin_out), .thermal_event_pin_oe(thermal_event_pin_oe), .irq(irq));
